// ===== hdl/timer16_ctc.sv
// 16-bit timer with compare outputs, normal and clear-on-match modes
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defines.svh"
module timer16_core (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Compare output pins, A in bit 0, B in bit 1
    output logic [1:0]       pin_out,
    output logic [1:0]       pin_oe_n
);
    import timer16_pkg::*;

    regs_t       r_q;
    regs_t       r_d;
    logic        tick;
    logic        do_wr;
    logic        cnt_wr;
    logic        sts_wr;
    logic [31:0] sts_clr;
    logic [1:0]  force_cmp;
    logic [1:0]  match;
    logic [1:0]  oc_state;
    logic        pwm;
    logic        at_top;
    logic        bottom;
    logic [15:0] top;
    logic [15:0] cmp [2];

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    function automatic logic mapped(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= `OFS_PORT);
    endfunction : mapped

    // ****************************************************************
    // Counting: waveform mode, top and register write decodes
    // ****************************************************************
    always_comb begin
        unique case (r_q.wgm)
            4'h1, 4'h5: top = `TOP_FIX8;
            4'h2, 4'h6: top = `TOP_FIX9;
            4'h3, 4'h7: top = `TOP_FIX10;
            4'h4, 4'h9, 4'hB, 4'hF: top = r_q.cmp_a;
            4'h8, 4'hA, 4'hC, 4'hE: top = r_q.cap_top;
            default: top = `CNT_MAX;
        endcase
    end

    assign pwm    = (r_q.wgm != `WGM_NORMAL) && (r_q.wgm != `WGM_CLR_A)
                    && (r_q.wgm != `WGM_CLR_CAP);
    assign at_top = (r_q.cnt == top);
    assign cmp[0] = r_q.cmp_a;
    assign cmp[1] = r_q.cmp_b;
    assign bottom = pwm && tick && at_top && !r_q.block;
    assign do_wr  = r_q.aw_have && r_q.w_have && !r_q.bvalid;
    assign cnt_wr = do_wr && (r_q.aw_addr == `OFS_COUNT);
    assign sts_wr = do_wr && (r_q.aw_addr == `OFS_STATUS);
    assign sts_clr = sts_wr ? (r_q.w_data & {29'h0, {3{r_q.w_strb[0]}}})
                            : 32'h0000_0000;

    // ****************************************************************
    // Compare channels
    // ****************************************************************
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_ch
            assign match[ch] = tick && !r_q.block
                               && (r_q.cnt == cmp[ch]);
            assign force_cmp[ch] = do_wr && !pwm
                                   && (r_q.aw_addr == `OFS_FORCE)
                                   && r_q.w_strb[0] && r_q.w_data[ch];
            timer16_compare_channel u_ch (
                .aclk      (aclk),
                .aresetn   (aresetn),
                .mode      (cmode_t'(r_q.cmode[ch*2 +: 2])),
                .pwm       (pwm),
                .match     (match[ch]),
                .bottom    (bottom),
                .force_cmp (force_cmp[ch]),
                .port_data (r_q.port_data[ch]),
                .pin_dir   (r_q.pin_dir[ch]),
                .oc_state  (oc_state[ch]),
                .pin_out   (pin_out[ch]),
                .pin_oe_n  (pin_oe_n[ch])
            );
        end
    endgenerate

    timer16_prescaler u_pre (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clk_sel (r_q.csel),
        .tick    (tick)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic [31:0] v;
        v   = 32'h0000_0000;
        r_d = r_q;
        // Counter; a software write wins over the tick
        if (cnt_wr) begin
            v = merge({16'h0000, r_q.cnt}, r_q.w_data, r_q.w_strb);
            r_d.cnt = v[15:0];
        end else if (tick) begin
            if (at_top && !r_q.block) begin
                r_d.cnt = `RST_WORD16;
            end else begin
                r_d.cnt = r_q.cnt + 16'h0001;
            end
        end
        // Matches in the tick after a counter write are dropped
        if (cnt_wr) begin
            r_d.block = 1'b1;
        end else if (tick) begin
            r_d.block = 1'b0;
        end
        // Sticky flags, set wins over a write-one clear
        if (sts_clr[`STS_OVF_BIT]) begin
            r_d.ovf = 1'b0;
        end
        if (sts_clr[`STS_MFA_BIT]) begin
            r_d.mf_a = 1'b0;
        end
        if (sts_clr[`STS_MFB_BIT]) begin
            r_d.mf_b = 1'b0;
        end
        if (tick && !cnt_wr && (pwm ? (at_top && !r_q.block)
                                    : (r_q.cnt == `CNT_MAX))) begin
            r_d.ovf = 1'b1;
        end
        if (match[0]) begin
            r_d.mf_a = 1'b1;
        end
        if (match[1]) begin
            r_d.mf_b = 1'b1;
        end
        // Register writes
        if (do_wr) begin
            r_d.aw_have = 1'b0;
            r_d.w_have  = 1'b0;
            r_d.bvalid  = 1'b1;
            r_d.bresp   = mapped(r_q.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
            v = merge(32'h0000_0000, r_q.w_data, r_q.w_strb);
            unique case (r_q.aw_addr)
                `OFS_CTRL: begin
                    r_d.wgm  = v[`CTRL_WGM_LSB +: 4];
                    r_d.csel = v[`CTRL_CSEL_LSB +: 3];
                end
                `OFS_CMODE: r_d.cmode = v[3:0];
                `OFS_CMP_A: r_d.cmp_a = v[15:0] | (r_q.cmp_a
                                    & {{8{!r_q.w_strb[1]}},
                                       {8{!r_q.w_strb[0]}}});
                `OFS_CMP_B: r_d.cmp_b = v[15:0] | (r_q.cmp_b
                                    & {{8{!r_q.w_strb[1]}},
                                       {8{!r_q.w_strb[0]}}});
                `OFS_CAP_TOP: r_d.cap_top = v[15:0] | (r_q.cap_top
                                    & {{8{!r_q.w_strb[1]}},
                                       {8{!r_q.w_strb[0]}}});
                `OFS_PORT: begin
                    if (r_q.w_strb[0]) begin
                        r_d.port_data = v[1:0];
                        r_d.pin_dir   = v[`PORT_DIR_LSB +: 2];
                    end
                end
                default: begin
                end
            endcase
        end
        if (r_q.bvalid && s_axi_bready) begin
            r_d.bvalid = 1'b0;
        end
        if (s_axi_awvalid && !r_q.aw_have) begin
            r_d.aw_have = 1'b1;
            r_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r_q.w_have) begin
            r_d.w_have = 1'b1;
            r_d.w_data = s_axi_wdata;
            r_d.w_strb = s_axi_wstrb;
        end
        // Register reads
        if (r_q.rvalid && s_axi_rready) begin
            r_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !r_q.rvalid) begin
            r_d.rvalid = 1'b1;
            r_d.rresp  = mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            unique case (s_axi_araddr)
                `OFS_CTRL:    r_d.rdata = {25'h0, r_q.csel, r_q.wgm};
                `OFS_CMODE:   r_d.rdata = {28'h0, r_q.cmode};
                `OFS_COUNT:   r_d.rdata = {16'h0, r_q.cnt};
                `OFS_CMP_A:   r_d.rdata = {16'h0, r_q.cmp_a};
                `OFS_CMP_B:   r_d.rdata = {16'h0, r_q.cmp_b};
                `OFS_CAP_TOP: r_d.rdata = {16'h0, r_q.cap_top};
                `OFS_STATUS:  r_d.rdata = {29'h0, r_q.mf_b, r_q.mf_a,
                                           r_q.ovf};
                `OFS_PORT:    r_d.rdata = {26'h0, oc_state, r_q.pin_dir,
                                           r_q.port_data};
                default:      r_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    // ****************************************************************
    // Bus outputs
    // ****************************************************************
    assign s_axi_awready = !r_q.aw_have;
    assign s_axi_wready  = !r_q.w_have;
    assign s_axi_bvalid  = r_q.bvalid;
    assign s_axi_bresp   = r_q.bresp;
    assign s_axi_arready = !r_q.rvalid;
    assign s_axi_rvalid  = r_q.rvalid;
    assign s_axi_rdata   = r_q.rdata;
    assign s_axi_rresp   = r_q.rresp;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wrap_at_max;
        tick && !cnt_wr && r_q.cnt == `CNT_MAX;
    endsequence

    sequence s_clr_top_hit;
        r_q.wgm == `WGM_CLR_A && tick && !cnt_wr && !r_q.block
        && r_q.cnt == r_q.cmp_a;
    endsequence

    // Zero now, and held unless that cycle ticked or wrote
    sequence s_held_zero;
        r_q.cnt == 16'h0000
        ##1 ($stable(r_q.cnt) || $past(tick) || $past(cnt_wr));
    endsequence

    a_normal_wrap: assert property (
        s_wrap_at_max and r_q.wgm == `WGM_NORMAL |=> r_q.cnt == 16'h0000)
        else $error("normal mode did not wrap to zero");
    a_normal_ovf: assert property (
        s_wrap_at_max and r_q.wgm == `WGM_NORMAL
        |=> r_q.ovf && r_q.cnt == 16'h0000)
        else $error("overflow not set with counter at zero");
    a_clr_ovf: assert property (
        s_wrap_at_max and r_q.wgm == `WGM_CLR_A |=> r_q.ovf)
        else $error("clear-on-match wrap missed overflow");
    a_clr_clear: assert property (
        s_clr_top_hit |=> s_held_zero)
        else $error("counter not cleared at compare A");
    a_ovf_sticky: assert property (
        r_q.ovf && !sts_clr[`STS_OVF_BIT] |=> r_q.ovf)
        else $error("overflow flag dropped without a clear");
    a_block_after_write: assert property (
        tick && r_q.block && !sts_wr
        |=> r_q.mf_a == $past(r_q.mf_a) && r_q.mf_b == $past(r_q.mf_b))
        else $error("match not blocked after counter write");
    a_force_no_flag: assert property (
        |force_cmp && !(|match) && !r_q.mf_a && !tick && !cnt_wr
        |=> !r_q.mf_a && $stable(r_q.cnt))
        else $error("force touched flag or counter");
    a_cnt_write: assert property (
        cnt_wr && (&r_q.w_strb[1:0]) |=> r_q.cnt == $past(r_q.w_data[15:0]))
        else $error("counter write not taken");

endmodule : timer16_core
`default_nettype wire

// ===== hdl/timer16_defines.svh
// Register offsets, field positions, reset values and prescaler masks
`ifndef TIMER16_DEFINES_SVH
`define TIMER16_DEFINES_SVH

`define OFS_CTRL      8'h00
`define OFS_CMODE     8'h04
`define OFS_FORCE     8'h08
`define OFS_COUNT     8'h0C
`define OFS_CMP_A     8'h10
`define OFS_CMP_B     8'h14
`define OFS_CAP_TOP   8'h18
`define OFS_STATUS    8'h1C
`define OFS_PORT      8'h20

`define CTRL_WGM_LSB  0
`define CTRL_CSEL_LSB 4
`define STS_OVF_BIT   0
`define STS_MFA_BIT   1
`define STS_MFB_BIT   2
`define PORT_DIR_LSB  2
`define PORT_OC_LSB   4

`define RST_WORD16    16'h0000
`define CNT_MAX       16'hFFFF
`define TOP_FIX8      16'h00FF
`define TOP_FIX9      16'h01FF
`define TOP_FIX10     16'h03FF

`define WGM_NORMAL    4'h0
`define WGM_CLR_A     4'h4
`define WGM_CLR_CAP   4'hC

`define DIV1_MASK     10'h000
`define DIV8_MASK     10'h007
`define DIV64_MASK    10'h03F
`define DIV256_MASK   10'h0FF
`define DIV1024_MASK  10'h3FF

`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// ===== hdl/timer16_pkg.sv
// Types shared by the timer and its compare channels
package timer16_pkg;

    typedef enum logic [1:0] {
        CM_OFF    = 2'h0,
        CM_TOGGLE = 2'h1,
        CM_CLEAR  = 2'h2,
        CM_SET    = 2'h3
    } cmode_t;

    typedef struct packed {
        logic [9:0] div;
        logic       tick;
    } pre_t;

    typedef struct packed {
        logic oc;
        logic pin;
        logic oe_n;
    } chan_t;

    typedef struct packed {
        logic        aw_have;
        logic [7:0]  aw_addr;
        logic        w_have;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [3:0]  wgm;
        logic [2:0]  csel;
        logic [3:0]  cmode;
        logic [15:0] cnt;
        logic [15:0] cmp_a;
        logic [15:0] cmp_b;
        logic [15:0] cap_top;
        logic [1:0]  port_data;
        logic [1:0]  pin_dir;
        logic        ovf;
        logic        mf_a;
        logic        mf_b;
        logic        block;
    } regs_t;

endpackage : timer16_pkg

// ===== hdl/timer16_prescaler.sv
// Timer clock enable from a free-running system clock divider
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defines.svh"
module timer16_prescaler (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Clock select: 0 stopped, 1..5 divide by 1, 8, 64, 256, 1024
    input  wire logic [2:0] clk_sel,
    // Timer clock enable
    output logic            tick
);
    import timer16_pkg::*;

    pre_t s_q;
    pre_t s_d;
    logic [9:0] mask;

    always_comb begin
        s_d = s_q;
        unique case (clk_sel)
            3'h1: mask = `DIV1_MASK;
            3'h2: mask = `DIV8_MASK;
            3'h3: mask = `DIV64_MASK;
            3'h4: mask = `DIV256_MASK;
            default: mask = `DIV1024_MASK;
        endcase
        s_d.div  = s_q.div + 10'h001;
        s_d.tick = (clk_sel >= 3'h1) && (clk_sel <= 3'h5)
                   && ((s_q.div & mask) == mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;

endmodule : timer16_prescaler
`default_nettype wire

// ===== hdl/timer16_compare_channel.sv
// One compare output channel: output state and pin override
`timescale 1ns/1ps
`default_nettype none
module timer16_compare_channel (
    // Clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // Channel control
    input  wire timer16_pkg::cmode_t    mode,
    input  wire logic                   pwm,
    input  wire logic                   match,
    input  wire logic                   bottom,
    input  wire logic                   force_cmp,
    // Port
    input  wire logic                   port_data,
    input  wire logic                   pin_dir,
    output logic                        oc_state,
    output logic                        pin_out,
    output logic                        pin_oe_n
);
    import timer16_pkg::*;

    chan_t s_q;
    chan_t s_d;

    always_comb begin
        s_d = s_q;
        if (!pwm) begin
            if (match || force_cmp) begin
                unique case (mode)
                    CM_OFF:    s_d.oc = s_q.oc;
                    CM_TOGGLE: s_d.oc = !s_q.oc;
                    CM_CLEAR:  s_d.oc = 1'b0;
                    CM_SET:    s_d.oc = 1'b1;
                endcase
            end
        end else begin
            // Bottom wins so compare equal to top gives a flat level
            if (mode == CM_CLEAR) begin
                if (bottom) begin
                    s_d.oc = 1'b1;
                end else if (match) begin
                    s_d.oc = 1'b0;
                end
            end else if (mode == CM_SET) begin
                if (bottom) begin
                    s_d.oc = 1'b0;
                end else if (match) begin
                    s_d.oc = 1'b1;
                end
            end
        end
        s_d.pin  = (mode != CM_OFF) ? s_d.oc : port_data;
        s_d.oe_n = !pin_dir;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign oc_state = s_q.oc;
    assign pin_out  = s_q.pin;
    assign pin_oe_n = s_q.oe_n;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_mode_zero_hold: assert property (
        mode == CM_OFF |=> $stable(oc_state))
        else $error("output state moved with mode zero");
    a_toggle_on_event: assert property (
        !pwm && mode == CM_TOGGLE && (match || force_cmp)
        |=> oc_state != $past(oc_state))
        else $error("toggle mode did not toggle");
    a_clear_set_event: assert property (
        !pwm && (match || force_cmp) && mode[1]
        |=> oc_state == $past(mode[0]))
        else $error("clear or set mode gave wrong level");
    a_pin_override: assert property (
        mode != CM_OFF |=> pin_out == oc_state)
        else $error("pin not driven from output state");
    a_pin_direction: assert property (
        !pin_dir |=> pin_oe_n)
        else $error("pin driven while direction is input");

endmodule : timer16_compare_channel
`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench for the 16-bit timer compare output block
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defines.svh"
module tb;
    // ************************************************************
    // Signals
    // ************************************************************
    logic        aclk, aresetn, awvalid, awready, wvalid, wready;
    logic        bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, data;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp, pin_out, pin_oe_n;
    logic        prev, last_pin;
    int          mismatches, compares, toggles, t0;
    logic [7:0]  regs [6] = '{`OFS_CTRL, `OFS_CMODE, `OFS_COUNT,
                              `OFS_CMP_A, `OFS_STATUS, `OFS_PORT};
    logic [1:0]  fm [5] = '{2'h3, 2'h0, 2'h2, 2'h1, 2'h1};
    logic        fx [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [3:0]  cw [2] = '{`WGM_CLR_A, `WGM_CLR_CAP};
    logic [15:0] ca [2] = '{16'h0005, 16'h0003};

    timer16_core timer16_core_inst (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n));

    always #5 aclk = ~aclk;

    // Counts level changes of pin A
    always @(posedge aclk) begin
        if (pin_out[0] !== last_pin)
            toggles <= toggles + 1;
        last_pin <= pin_out[0];
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : chk

    task automatic end_sim;
        $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim

    // One clock edge of a bounded wait
    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 50) begin
            mismatches++;
            end_sim;
        end
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int   n;
        logic aw, w;
        n = 0;
        aw = 1'b1;
        w = 1'b1;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (aw || w) begin
            tick(n);
            if (aw && awready === 1'b1) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready === 1'b1) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do tick(n); while (bvalid !== 1'b1);
        resp = bresp;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do tick(n); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do tick(n); while (rvalid !== 1'b1);
        data = rdata;
        resp = rresp;
    endtask : rd

    // Runs the counter at full rate for a number of cycles
    task automatic run(input logic [3:0] wgm, input int cyc);
        wr(`OFS_CTRL, {25'h0, 3'h1, wgm});
        repeat (cyc) @(posedge aclk);
        wr(`OFS_CTRL, 32'h0);
    endtask : run

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {awvalid, wvalid, arvalid, last_pin} = 4'h0;
        {bready, rready} = 2'h3;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hF;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (regs[k]) begin
            rd(regs[k]);
            chk(data, 32'h0);
        end
        chk({30'h0, pin_out}, 32'h0);
        wr(8'h40, 32'h1);
        chk(32'(resp), 32'(`RESP_SLVERR));
        rd(8'h40);
        chk(32'(resp), 32'(`RESP_SLVERR));
        $display("Test reset and map done");
        wr(`OFS_COUNT, 32'h1234);
        prev = 1'b0;
        for (int i = 0; i < 5; i++) begin
            wr(`OFS_CMODE, {30'h0, fm[i]});
            rd(`OFS_PORT);
            chk(32'(data[4]), 32'(prev));
            wr(`OFS_FORCE, 32'h1);
            rd(`OFS_PORT);
            chk(32'(data[4]), 32'(fx[i]));
            prev = fx[i];
        end
        wr(`OFS_CMODE, 32'hC);
        wr(`OFS_FORCE, 32'h2);
        rd(`OFS_PORT);
        chk(32'(data[5]), 32'h1);
        rd(`OFS_STATUS);
        chk(data, 32'h0);
        rd(`OFS_COUNT);
        chk(data, 32'h1234);
        $display("Test force compare done");
        wr(`OFS_CMODE, 32'h0);
        wr(`OFS_PORT, 32'h1);
        repeat (3) @(posedge aclk);
        chk(32'(pin_oe_n[0]), 32'h1);
        wr(`OFS_PORT, 32'h5);
        repeat (3) @(posedge aclk);
        chk({30'h0, pin_oe_n[0], pin_out[0]}, 32'h1);
        wr(`OFS_CMODE, 32'h2);
        repeat (3) @(posedge aclk);
        chk(32'(pin_out[0]), 32'h0);
        wr(`OFS_PORT, 32'h1);
        wr(`OFS_CMODE, 32'h3);
        wr(`OFS_FORCE, 32'h1);
        wr(`OFS_PORT, 32'h4);
        repeat (3) @(posedge aclk);
        chk({30'h0, pin_oe_n[0], pin_out[0]}, 32'h1);
        $display("Test pin override done");
        wr(`OFS_COUNT, 32'hFFF0);
        wr(`OFS_CMP_A, 32'h8000);
        wr(`OFS_STATUS, 32'h7);
        run(`WGM_NORMAL, 40);
        rd(`OFS_COUNT);
        chk(32'(data < 32'h40), 32'h1);
        rd(`OFS_STATUS);
        chk(32'(data[0]), 32'h1);
        wr(`OFS_STATUS, 32'h1);
        rd(`OFS_STATUS);
        chk(32'(data[0]), 32'h0);
        wr(`OFS_CMP_A, 32'h0100);
        wr(`OFS_COUNT, 32'h0100);
        run(`WGM_NORMAL, 5);
        rd(`OFS_STATUS);
        chk(32'(data[1]), 32'h0);
        $display("Test normal mode done");
        wr(`OFS_CMODE, 32'h1);
        wr(`OFS_CAP_TOP, 32'h5);
        for (int i = 0; i < 2; i++) begin
            wr(`OFS_CMP_A, {16'h0, ca[i]});
            wr(`OFS_COUNT, 32'h0);
            wr(`OFS_STATUS, 32'h7);
            t0 = toggles;
            run(cw[i], 60);
            rd(`OFS_COUNT);
            chk(32'(data <= 32'h5), 32'h1);
            rd(`OFS_STATUS);
            chk(32'(data[1:0]), 32'h2);
            chk(32'(toggles - t0 >= 5), 32'h1);
        end
        rd(`OFS_CAP_TOP);
        chk(data, 32'h5);
        $display("Test clear on match done");
        // Top 7 from compare A, B matches at 1: B high 2 of 8 ticks in clear mode, 6 of 8 in set mode
        wr(`OFS_CMP_A, 32'h7);
        wr(`OFS_CMP_B, 32'h1);
        wr(`OFS_PORT, 32'h8);
        for (int i = 2; i < 4; i++) begin
            wr(`OFS_CMODE, i << 2);
            wr(`OFS_CTRL, 32'h1F);
            repeat (20) @(posedge aclk);
            t0 = 0;
            repeat (16) @(posedge aclk) t0 += pin_out[1];
            wr(`OFS_CTRL, 32'h0);
            chk(t0, (i == 2) ? 32'h4 : 32'hC);
            chk(32'(pin_oe_n), 32'h1);
        end
        $display("Test PWM polarity done");
        end_sim;
    end
endmodule : tb
`default_nettype wire
